// ---- include/sbc_defines.svh ----
// constants for the bank and clock-enable command state tracker
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

// ****************************************
// clock
// ****************************************
`define SBC_CLK_MHZ 250

// ****************************************
// timing in ns and cycle conversion
// ****************************************
`define SBC_T_RCD_NS 20
`define SBC_T_RP_NS 20
`define SBC_T_WR_NS 15
`define SBC_T_XSR_NS 75
`define SBC_T_RFC_NS 66
// least times round up to whole cycles
`define SBC_CYC_UP(ns) ((((ns) * `SBC_CLK_MHZ) + 999) / 1000)

// ****************************************
// defaults
// ****************************************
`define SBC_NUM_BANKS 4
`define SBC_READ_LATENCY 2
`define SBC_BURST_LEN 4
`define SBC_TIMER_W 8

`endif

// ---- include/sbc_pkg.sv ----
// types for the bank and clock-enable command state tracker
`default_nettype none

package sbc_pkg;

  typedef enum logic [3:0] {
    CMD_INHIBIT,
    CMD_NOP,
    CMD_ACTIVE,
    CMD_READ,
    CMD_WRITE,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_LOAD_MODE,
    CMD_TERMINATE
  } sbc_cmd_e;

  typedef enum logic [2:0] {
    BANK_IDLE,
    BANK_ACTIVATING,
    BANK_ACTIVE,
    BANK_READ,
    BANK_WRITE,
    BANK_READ_AP,
    BANK_WRITE_AP,
    BANK_PRECHARGING
  } sbc_bank_e;

  typedef enum logic [1:0] {
    AP_BURST,
    AP_RECOVER,
    AP_PRECHARGE
  } sbc_ap_e;

  typedef enum logic [2:0] {
    DEV_NORMAL,
    DEV_REFRESH,
    DEV_POWER_DOWN,
    DEV_SELF_REFRESH,
    DEV_SR_EXIT,
    DEV_SUSPEND
  } sbc_dev_e;

endpackage : sbc_pkg

`default_nettype wire

// ---- rtl/sbc_beat_buffer.sv ----
// small valid/ready buffer for data beat records
`default_nettype none

module sbc_beat_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
    $error("sbc_beat_buffer: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != CNT_W'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

  // storage needs no reset; out_valid_o guards it
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule : sbc_beat_buffer

`default_nettype wire

// ---- rtl/sbc_bank_control.sv ----
// per-bank command state, burst interruption and clock-enable power states
`default_nettype none

`include "sbc_defines.svh"

module sbc_bank_control import sbc_pkg::*; #(
  parameter int NUM_BANKS = `SBC_NUM_BANKS,
  parameter int READ_LATENCY = `SBC_READ_LATENCY,
  parameter int BURST_LEN = `SBC_BURST_LEN,
  parameter int TIMER_W = `SBC_TIMER_W,
  parameter int BANK_W = $clog2(NUM_BANKS),
  parameter int IDX_W = $clog2(BURST_LEN)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic auto_precharge_i,
  input wire logic beat_ready_i,
  output logic beat_valid_o,
  output logic beat_write_o,
  output logic [BANK_W-1:0] beat_bank_o,
  output logic [IDX_W-1:0] beat_index_o,
  output logic [NUM_BANKS*3-1:0] bank_state_o,
  output logic [2:0] dev_state_o,
  output logic illegal_o
);

  // ****************************************
  // configuration
  // ****************************************
  localparam int REM_W = $clog2(BURST_LEN + 1);
  localparam int PW = 1 + BANK_W + IDX_W;
  localparam logic [TIMER_W-1:0] RCD_CYC = TIMER_W'(`SBC_CYC_UP(`SBC_T_RCD_NS));
  localparam logic [TIMER_W-1:0] RP_CYC = TIMER_W'(`SBC_CYC_UP(`SBC_T_RP_NS));
  localparam logic [TIMER_W-1:0] WR_CYC = TIMER_W'(`SBC_CYC_UP(`SBC_T_WR_NS));
  localparam logic [TIMER_W-1:0] XSR_CYC = TIMER_W'(`SBC_CYC_UP(`SBC_T_XSR_NS));
  localparam logic [TIMER_W-1:0] RFC_CYC = TIMER_W'(`SBC_CYC_UP(`SBC_T_RFC_NS));

  if (NUM_BANKS < 2 || (NUM_BANKS & (NUM_BANKS - 1)) != 0) begin : g_bad_banks
    $error("sbc_bank_control: NUM_BANKS must be a power of two of at least 2");
  end
  if (READ_LATENCY < 1 || READ_LATENCY > 3) begin : g_bad_lat
    $error("sbc_bank_control: READ_LATENCY must be 1 to 3");
  end
  if (BURST_LEN < 2 || BURST_LEN > 8 || (BURST_LEN & (BURST_LEN - 1)) != 0) begin : g_bad_bl
    $error("sbc_bank_control: BURST_LEN must be 2, 4 or 8");
  end
  if (`SBC_CYC_UP(`SBC_T_XSR_NS) >= (1 << TIMER_W)) begin : g_bad_tw
    $error("sbc_bank_control: TIMER_W too narrow for the timing counts");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic sbc_cmd_e decode(input logic cs_n, input logic [2:0] rcw);
    sbc_cmd_e c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_INHIBIT;
    end else begin
      case (rcw)
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACTIVE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_REFRESH;
        3'h0: c = CMD_LOAD_MODE;
        3'h6: c = CMD_TERMINATE;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode

  // what a bank's own state permits
  function automatic logic cmd_ok(input sbc_bank_e st, input sbc_cmd_e c);
    logic ok;
    ok = 1'b0;
    case (c)
      CMD_ACTIVE: ok = (st == BANK_IDLE);
      CMD_READ, CMD_WRITE: ok = (st == BANK_ACTIVE) || (st == BANK_READ) || (st == BANK_WRITE);
      CMD_PRECHARGE: ok = (st == BANK_IDLE) || (st == BANK_ACTIVE)
                          || (st == BANK_READ) || (st == BANK_WRITE);
      default: ok = 1'b1;
    endcase
    return ok;
  endfunction : cmd_ok

  function automatic logic in_burst(input sbc_bank_e st, input sbc_ap_e ph);
    return (st == BANK_READ) || (st == BANK_WRITE)
           || (((st == BANK_READ_AP) || (st == BANK_WRITE_AP)) && (ph == AP_BURST));
  endfunction : in_burst

  function automatic logic is_nop(input sbc_cmd_e c);
    return (c == CMD_NOP) || (c == CMD_INHIBIT);
  endfunction : is_nop

  // ****************************************
  // state
  // ****************************************
  sbc_bank_e bank_st [NUM_BANKS];
  sbc_ap_e ap_ph [NUM_BANKS];
  logic [TIMER_W-1:0] timer [NUM_BANKS];
  sbc_dev_e dev;
  logic [TIMER_W-1:0] dev_timer;
  logic cke_q;
  logic [BANK_W-1:0] cur_bank;
  logic [REM_W-1:0] data_rem;
  logic [BANK_W-1:0] data_bank;
  logic data_wr;
  logic [IDX_W-1:0] data_idx;
  logic [READ_LATENCY-1:0] rp_vld;
  logic [BANK_W-1:0] rp_bank [READ_LATENCY];

  sbc_cmd_e cmd;
  logic live;
  logic all_idle;
  logic tgt_ok;
  logic act_go;
  logic col_go;
  logic rd_go;
  logic wr_go;
  logic pre_go;
  logic bst_go;
  logic cke_fall;
  logic cke_rise;
  logic data_busy;
  logic susp_enter;
  logic freeze;
  logic push;
  logic buf_ready;
  logic rp_out;
  logic burst_done;
  logic pre_kill;
  logic [NUM_BANKS-1:0] pre_hit;
  logic [NUM_BANKS-1:0] intr;
  logic [NUM_BANKS-1:0] done;

  // ****************************************
  // command qualification
  // ****************************************
  assign cmd = decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
  assign cke_fall = cke_q && !cke_i;
  assign cke_rise = !cke_q && cke_i;
  assign live = cke_q && cke_i && (dev == DEV_NORMAL);
  assign tgt_ok = cmd_ok(bank_st[ba_i], cmd);
  assign act_go = live && (cmd == CMD_ACTIVE) && tgt_ok;
  assign col_go = live && ((cmd == CMD_READ) || (cmd == CMD_WRITE)) && tgt_ok;
  assign rd_go = col_go && (cmd == CMD_READ);
  assign wr_go = col_go && (cmd == CMD_WRITE);
  assign pre_go = live && (cmd == CMD_PRECHARGE);
  assign bst_go = live && (cmd == CMD_TERMINATE)
                  && in_burst(bank_st[cur_bank], ap_ph[cur_bank]);
  assign rp_out = rp_vld[READ_LATENCY-1];
  assign data_busy = (data_rem != '0) || (rp_vld != '0);
  assign susp_enter = (dev == DEV_NORMAL) && cke_fall && data_busy;
  // clock suspend freezes every internal timer and the data beats
  assign freeze = (dev == DEV_SUSPEND) || susp_enter;
  assign push = !freeze && (data_rem != '0) && buf_ready;
  assign burst_done = push && (data_rem == REM_W'(1)) && (rp_vld == '0) && !col_go;
  assign pre_kill = pre_go && pre_hit[data_bank];

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bank_st[b] != BANK_IDLE) begin
        all_idle = 1'b0;
      end
      pre_hit[b] = pre_go && (auto_precharge_i || (ba_i == BANK_W'(b)))
                   && ((bank_st[b] == BANK_ACTIVE) || (bank_st[b] == BANK_READ)
                       || (bank_st[b] == BANK_WRITE));
      intr[b] = col_go && (ba_i != BANK_W'(b)) && (cur_bank == BANK_W'(b))
                && in_burst(bank_st[b], ap_ph[b]);
      done[b] = burst_done && (data_bank == BANK_W'(b)) && in_burst(bank_st[b], ap_ph[b]);
    end
  end

  // ****************************************
  // per-bank state
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_st[b] <= BANK_IDLE;
        ap_ph[b] <= AP_BURST;
        timer[b] <= '0;
      end
    end else if (!freeze) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        if (timer[b] != '0) begin
          timer[b] <= timer[b] - 1'b1;
        end
        if (act_go && (ba_i == BANK_W'(b))) begin
          bank_st[b] <= BANK_ACTIVATING;
          timer[b] <= RCD_CYC - 1'b1;
        end else if (col_go && (ba_i == BANK_W'(b))) begin
          ap_ph[b] <= AP_BURST;
          if (cmd == CMD_READ) begin
            bank_st[b] <= auto_precharge_i ? BANK_READ_AP : BANK_READ;
          end else begin
            bank_st[b] <= auto_precharge_i ? BANK_WRITE_AP : BANK_WRITE;
          end
        end else if (pre_hit[b]) begin
          bank_st[b] <= BANK_PRECHARGING;
          timer[b] <= RP_CYC - 1'b1;
        end else if (intr[b] || done[b]) begin
          case (bank_st[b])
            BANK_READ, BANK_WRITE: bank_st[b] <= BANK_ACTIVE;
            BANK_READ_AP: begin
              ap_ph[b] <= AP_PRECHARGE;
              timer[b] <= RP_CYC - 1'b1;
            end
            BANK_WRITE_AP: begin
              ap_ph[b] <= AP_RECOVER;
              timer[b] <= WR_CYC - 1'b1;
            end
            default: begin
            end
          endcase
        end else if (bst_go && (cur_bank == BANK_W'(b))
                     && ((bank_st[b] == BANK_READ) || (bank_st[b] == BANK_WRITE))) begin
          bank_st[b] <= BANK_ACTIVE;
        end else if (timer[b] == '0) begin
          case (bank_st[b])
            BANK_ACTIVATING: bank_st[b] <= BANK_ACTIVE;
            BANK_PRECHARGING: bank_st[b] <= BANK_IDLE;
            BANK_READ_AP, BANK_WRITE_AP: begin
              if (ap_ph[b] == AP_RECOVER) begin
                ap_ph[b] <= AP_PRECHARGE;
                timer[b] <= RP_CYC - 1'b1;
              end else if (ap_ph[b] == AP_PRECHARGE) begin
                bank_st[b] <= BANK_IDLE;
                ap_ph[b] <= AP_BURST;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

  // ****************************************
  // current burst owner
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_bank <= '0;
    end else if (col_go && !freeze) begin
      cur_bank <= ba_i;
    end
  end

  // ****************************************
  // read latency pipe
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rp_vld <= '0;
      for (int i = 0; i < READ_LATENCY; i++) begin
        rp_bank[i] <= '0;
      end
    end else if (!freeze) begin
      // a write or terminate drops reads still waiting on their latency
      if (wr_go || bst_go) begin
        rp_vld <= '0;
      end else begin
        rp_vld[0] <= rd_go;
        for (int i = 1; i < READ_LATENCY; i++) begin
          rp_vld[i] <= rp_vld[i-1];
        end
      end
      rp_bank[0] <= ba_i;
      for (int i = 1; i < READ_LATENCY; i++) begin
        rp_bank[i] <= rp_bank[i-1];
      end
    end
  end

  // ****************************************
  // data beat tracking
  // ****************************************
  // while the beat buffer has room a pending beat is the pin beat of the previous edge, so an
  // interrupting command still records it before the reload
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_rem <= '0;
      data_bank <= '0;
      data_wr <= 1'b0;
      data_idx <= '0;
    end else if (!freeze) begin
      if (wr_go) begin
        data_rem <= REM_W'(BURST_LEN);
        data_bank <= ba_i;
        data_wr <= 1'b1;
        data_idx <= '0;
      end else if ((rd_go && data_wr) || bst_go || pre_kill) begin
        data_rem <= '0;
      end else if (rp_out) begin
        data_rem <= REM_W'(BURST_LEN);
        data_bank <= rp_bank[READ_LATENCY-1];
        data_wr <= 1'b0;
        data_idx <= '0;
      end else if (push) begin
        data_rem <= data_rem - 1'b1;
        data_idx <= data_idx + 1'b1;
      end
    end
  end

  sbc_beat_buffer #(
    .WIDTH(PW),
    .DEPTH(2)
  ) u_beat_buffer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push),
    .in_ready_o(buf_ready),
    .in_data_i({data_wr, data_bank, data_idx}),
    .out_valid_o(beat_valid_o),
    .out_ready_i(beat_ready_i),
    .out_data_o({beat_write_o, beat_bank_o, beat_index_o})
  );

  // ****************************************
  // clock enable and device state
  // ****************************************
  // reset lands in power-down so the power-up clock enable rise needs a no-op
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cke_q <= 1'b0;
      dev <= DEV_POWER_DOWN;
      dev_timer <= '0;
    end else begin
      cke_q <= cke_i;
      case (dev)
        DEV_NORMAL: begin
          if (cke_fall) begin
            if (all_idle && (cmd == CMD_REFRESH)) begin
              dev <= DEV_SELF_REFRESH;
            end else if (all_idle && is_nop(cmd)) begin
              dev <= DEV_POWER_DOWN;
            end else if (data_busy) begin
              dev <= DEV_SUSPEND;
            end
          end else if (live && (cmd == CMD_REFRESH) && all_idle) begin
            dev <= DEV_REFRESH;
            dev_timer <= RFC_CYC - 1'b1;
          end
        end
        DEV_REFRESH: begin
          if (dev_timer == '0) begin
            dev <= DEV_NORMAL;
          end else begin
            dev_timer <= dev_timer - 1'b1;
          end
        end
        DEV_POWER_DOWN: begin
          if (cke_rise && is_nop(cmd)) begin
            dev <= DEV_NORMAL;
          end
        end
        DEV_SELF_REFRESH: begin
          if (cke_rise && is_nop(cmd)) begin
            dev <= DEV_SR_EXIT;
            dev_timer <= XSR_CYC - 1'b1;
          end
        end
        DEV_SR_EXIT: begin
          if (dev_timer == '0) begin
            dev <= DEV_NORMAL;
          end else begin
            dev_timer <= dev_timer - 1'b1;
          end
        end
        DEV_SUSPEND: begin
          if (cke_rise) begin
            dev <= DEV_NORMAL;
          end
        end
        default: dev <= DEV_NORMAL;
      endcase
    end
  end

  // ****************************************
  // illegal command flag
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      illegal_o <= 1'b0;
    end else begin
      illegal_o <= (live && ((cmd == CMD_ACTIVE) || (cmd == CMD_READ)
                             || (cmd == CMD_WRITE) || (cmd == CMD_PRECHARGE)) && !tgt_ok)
                   || (live && ((cmd == CMD_REFRESH) || (cmd == CMD_LOAD_MODE))
                       && !all_idle)
                   || (live && (cmd == CMD_TERMINATE) && !bst_go)
                   || (cke_rise && !is_nop(cmd)
                       && ((dev == DEV_POWER_DOWN) || (dev == DEV_SELF_REFRESH)))
                   || ((dev == DEV_SR_EXIT) && !is_nop(cmd));
    end
  end

  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      bank_state_o[b*3 +: 3] = bank_st[b];
    end
  end

  assign dev_state_o = dev;

endmodule : sbc_bank_control

`default_nettype wire

// ---- dv/sbc_bank_control_props.sv ----
// checker: port-level properties of the bank control block
`default_nettype none

module sbc_bank_control_props import sbc_pkg::*; #(
  parameter int NUM_BANKS = 4,
  parameter int BANK_W = 2,
  parameter int IDX_W = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BANK_W-1:0] ba_i,
  input wire logic auto_precharge_i,
  input wire logic beat_ready_i,
  input wire logic beat_valid_o,
  input wire logic beat_write_o,
  input wire logic [BANK_W-1:0] beat_bank_o,
  input wire logic [IDX_W-1:0] beat_index_o,
  input wire logic [NUM_BANKS*3-1:0] bank_state_o,
  input wire logic [2:0] dev_state_o,
  input wire logic illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // helpers
  // ****
  logic cke_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cke_q <= 1'b0;
    else cke_q <= cke_i;
  end
  wire [2:0] rcw = {ras_n_i, cas_n_i, we_n_i};
  wire [2:0] b0 = bank_state_o[2:0];
  wire run = cke_i & cke_q & (dev_state_o == 3'h0) & !cs_n_i;
  wire quiet = cs_n_i | (rcw == 3'h7);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_act;
    (b0 == 3'h1) [*5] ##1 (b0 == 3'h2);
  endsequence
  sequence s_pre;
    (b0 == 3'h7) [*5] ##1 (b0 == 3'h0);
  endsequence
  inhibit_holds_a: assert property (
    cs_n_i && cke_i && cke_q && b0 == 3'h0 |=> b0 == 3'h0) else $error("inhibit moved a bank");
  act_timing_a: assert property (
    run && rcw == 3'h3 && ba_i == 0 && b0 == 3'h0 |=> s_act) else $error("activate timing");
  pre_timing_a: assert property (
    run && rcw == 3'h2 && ba_i == 0 && !auto_precharge_i && b0 == 3'h2 |=> s_pre)
    else $error("precharge timing");
  pd_entry_a: assert property (
    cke_q && !cke_i && dev_state_o == 3'h0 && bank_state_o == 0 && !beat_valid_o && quiet
    |=> dev_state_o == 3'h2) else $error("no power-down entry");
  sr_entry_a: assert property (
    cke_q && !cke_i && dev_state_o == 3'h0 && bank_state_o == 0 && !cs_n_i && rcw == 3'h1
    |=> dev_state_o == 3'h3) else $error("no self refresh entry");
  low_hold_a: assert property (
    !cke_q && !cke_i |=> $stable(dev_state_o) && $stable(bank_state_o))
    else $error("state moved with clock enable low");
  pd_exit_a: assert property (
    dev_state_o == 3'h2 && !cke_q && cke_i && quiet |=> dev_state_o == 3'h0)
    else $error("no power-down exit");
  sr_exit_a: assert property (
    dev_state_o == 3'h3 && !cke_q && cke_i && quiet
    |=> (dev_state_o == 3'h4) [*8] ##[10:13] (dev_state_o == 3'h0)) else $error("self refresh exit");
  term_flag_a: assert property (
    run && rcw == 3'h6 && bank_state_o == 0 |-> ##[1:2] illegal_o) else $error("stray terminate");
  ap_int_a: assert property (
    run && rcw == 3'h5 && ba_i == 1 && b0 == 3'h5 && bank_state_o[5:3] == 3'h2
    |-> ##[1:8] (b0 == 3'h0)) else $error("interrupted bank not precharged");
  beat_hold_a: assert property (
    beat_valid_o && !beat_ready_i |=> beat_valid_o &&
    $stable({beat_write_o, beat_bank_o, beat_index_o})) else $error("beat lost under stall");
endmodule : sbc_bank_control_props

bind sbc_bank_control sbc_bank_control_props #(.NUM_BANKS(NUM_BANKS), .BANK_W(BANK_W),
  .IDX_W(IDX_W)) u_sbc_bank_control_props (.*);

`default_nettype wire

// ---- dv/sbc_ctrl_model.sv ----
// controller model: puts commands on the strobes and paces the beat stream
`default_nettype none

module sbc_ctrl_model import sbc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input var sbc_cmd_e cmd_i,
  input wire logic stall_i,
  input wire logic [11:0] bank_state_i,
  output logic cs_n_o,
  output logic [2:0] rcw_o,
  output logic beat_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pace;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace <= 2'h0;
      beat_ready_o <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      // slow receiver takes one beat in four
      beat_ready_o <= !stall_i || (pace == 2'h0);
    end
  end
  // bank states tracked here only to hold back all-bank commands
  wire busy = |bank_state_i;
  always_comb begin
    cs_n_o = 1'b0;
    case (cmd_i)
      CMD_INHIBIT: begin
        // opcode left live: chip select alone must mask it
        cs_n_o = 1'b1;
        rcw_o = 3'h3;
      end
      CMD_ACTIVE: rcw_o = 3'h3;
      CMD_READ: rcw_o = 3'h5;
      CMD_WRITE: rcw_o = 3'h4;
      CMD_PRECHARGE: rcw_o = 3'h2;
      CMD_REFRESH: rcw_o = busy ? 3'h7 : 3'h1;
      CMD_LOAD_MODE: rcw_o = busy ? 3'h7 : 3'h0;
      CMD_TERMINATE: rcw_o = 3'h6;
      default: rcw_o = 3'h7;
    endcase
  end
endmodule : sbc_ctrl_model

`default_nettype wire

// ---- dv/tb_top.sv ----
// top testbench for the bank control block
`default_nettype none

module tb_top import sbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cke = 1'b0;
  logic stall = 1'b0;
  logic ap = 1'b0;
  logic [1:0] ba = 2'h0;
  sbc_cmd_e cmd = CMD_NOP;
  logic cs_n, ready, bv, bw, ill;
  logic [2:0] rcw, dev;
  logic [1:0] bb, bi;
  logic [11:0] bs;
  logic [4:0] recs[$];
  int num_errors = 0;
  int checks = 0;
  int n;

  initial begin
    forever #2 clk_i = ~clk_i;
  end
  sbc_ctrl_model u_sbc_ctrl_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd),
    .stall_i(stall), .bank_state_i(bs), .cs_n_o(cs_n), .rcw_o(rcw), .beat_ready_o(ready));
  sbc_bank_control u_sbc_bank_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]), .ba_i(ba),
    .auto_precharge_i(ap), .beat_ready_i(ready), .beat_valid_o(bv), .beat_write_o(bw),
    .beat_bank_o(bb), .beat_index_o(bi), .bank_state_o(bs), .dev_state_o(dev),
    .illegal_o(ill));
  always @(posedge clk_i) begin
    if (bv && ready) recs.push_back({bw, bb, bi});
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic issue(input sbc_cmd_e c, input logic [1:0] b, input logic a);
    @(posedge clk_i);
    cmd <= c;
    ba <= b;
    ap <= a;
    @(posedge clk_i);
    cmd <= CMD_NOP;
    #1;
  endtask : issue
  task automatic wait_st(input int sel, input logic [2:0] exp, output int k);
    k = 0;
    while ((sel == 2 ? dev : bs[3*sel+:3]) !== exp && k < 40) begin
      cyc(1);
      k++;
    end
  endtask : wait_st
  task automatic chk_burst(input logic w, input logic [1:0] b, input int sz);
    chk(12'(recs.size()), 12'(sz));
    for (int i = 0; i < 4; i++) begin
      chk(12'(recs[sz-4+i]), 12'({w, b, 2'(i)}));
    end
  endtask : chk_burst

  task automatic t_wake;
    chk(dev, 3'h2);
    @(posedge clk_i);
    cke <= 1'b1;
    cyc(1);
    chk(dev, 3'h0);
    $display("test wake done");
  endtask : t_wake
  task automatic t_act;
    issue(CMD_ACTIVE, 2'h0, 1'b0);
    issue(CMD_ACTIVE, 2'h1, 1'b0);
    chk(bs[5:0], 6'h09);
    cyc(7);
    chk(bs[5:0], 6'h12);
    $display("test activate done");
  endtask : t_act
  task automatic t_rd_ap;
    recs.delete();
    issue(CMD_READ, 2'h0, 1'b1);
    chk(bs[2:0], 3'h5);
    issue(CMD_READ, 2'h1, 1'b0);
    chk(bs[5:3], 3'h3);
    wait_st(0, 3'h0, n);
    chk(12'(n >= 4 && n <= 7), 12'h1);
    cyc(24);
    chk_burst(1'b0, 2'h1, 6);
    $display("test read interrupt done");
  endtask : t_rd_ap
  task automatic t_wr;
    issue(CMD_ACTIVE, 2'h0, 1'b0);
    cyc(7);
    recs.delete();
    issue(CMD_WRITE, 2'h0, 1'b1);
    chk(bs[2:0], 3'h6);
    issue(CMD_WRITE, 2'h1, 1'b0);
    cyc(3);
    chk(bs[2:0], 3'h6);
    wait_st(0, 3'h0, n);
    chk(12'(n >= 4 && n <= 7), 12'h1);
    cyc(8);
    chk_burst(1'b1, 2'h1, 6);
    $display("test write interrupt done");
  endtask : t_wr
  task automatic t_stall;
    @(posedge clk_i);
    stall <= 1'b1;
    recs.delete();
    issue(CMD_WRITE, 2'h1, 1'b0);
    cyc(30);
    chk_burst(1'b1, 2'h1, 4);
    @(posedge clk_i);
    stall <= 1'b0;
    $display("test stall done");
  endtask : t_stall
  task automatic t_pd;
    issue(CMD_ACTIVE, 2'h0, 1'b0);
    cyc(7);
    issue(CMD_PRECHARGE, 2'h0, 1'b0);
    issue(CMD_PRECHARGE, 2'h1, 1'b0);
    cyc(8);
    chk(bs, 12'h000);
    issue(CMD_INHIBIT, 2'h0, 1'b0);
    chk(bs, 12'h000);
    @(posedge clk_i);
    cke <= 1'b0;
    cyc(1);
    chk(dev, 3'h2);
    @(posedge clk_i);
    cmd <= CMD_ACTIVE;
    cyc(3);
    chk(bs, 12'h000);
    @(posedge clk_i);
    cmd <= CMD_NOP;
    cke <= 1'b1;
    cyc(1);
    chk(dev, 3'h0);
    $display("test power-down done");
  endtask : t_pd
  task automatic t_sr;
    @(posedge clk_i);
    cke <= 1'b0;
    cmd <= CMD_REFRESH;
    @(posedge clk_i);
    cmd <= CMD_NOP;
    cyc(1);
    chk(dev, 3'h3);
    @(posedge clk_i);
    cke <= 1'b1;
    cyc(1);
    chk(dev, 3'h4);
    wait_st(2, 3'h0, n);
    chk(12'(n >= 16 && n <= 20), 12'h1);
    issue(CMD_TERMINATE, 2'h0, 1'b0);
    n = 0;
    repeat (3) begin
      if (ill === 1'b1) n = 1;
      cyc(1);
    end
    chk(12'(n), 12'h1);
    $display("test self refresh done");
  endtask : t_sr

  task automatic t_mix;
    issue(CMD_ACTIVE, 2'h0, 1'b0);
    issue(CMD_ACTIVE, 2'h1, 1'b0);
    cyc(7);
    recs.delete();
    issue(CMD_WRITE, 2'h0, 1'b0);
    issue(CMD_READ, 2'h1, 1'b0);
    chk(bs[5:0], 6'h1a);
    // read still in its latency: clock enable low must suspend, not power down
    @(posedge clk_i);
    cke <= 1'b0;
    cyc(1);
    chk(dev, 3'h5);
    @(posedge clk_i);
    cke <= 1'b1;
    cyc(1);
    chk(dev, 3'h0);
    cyc(8);
    chk(12'(recs[1]), 12'h011);
    chk_burst(1'b0, 2'h1, 6);
    recs.delete();
    issue(CMD_READ, 2'h1, 1'b1);
    // a no-op edge stands before the write, room for the data mask
    issue(CMD_WRITE, 2'h0, 1'b0);
    chk(bs[5:0], 6'h2c);
    cyc(8);
    chk(bs[5:0], 6'h02);
    chk_burst(1'b1, 2'h0, 4);
    $display("test mixed interrupt done");
  endtask : t_mix

  task automatic wrap_up;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(1);
    t_wake();
    t_act();
    t_rd_ap();
    t_wr();
    t_stall();
    t_pd();
    t_sr();
    t_mix();
    wrap_up();
  end
endmodule : tb_top

`default_nettype wire
